// File: dp_host_model.sv
`timescale 1ns/100ps
// =====================================================================
// Host that drives the data port one frame at a time.
module dp_host_model
    import synth_lat_pkg::*;
(
    // Core clock that paces the host.
    input  wire logic              i_clk,
    // Data port pins.
    output logic                   o_dp_clk,
    output logic [31:0]            o_dp_data,
    output logic [FUNC_W-1:0]      o_dp_func,
    output logic                   o_dp_update,
    output logic [PROF_W-1:0]      o_dp_prof,
    output logic                   o_ramp_dir,
    output logic                   o_ramp_pause
);
    // Idle pins; the dp clock stands still outside frames.
    initial begin
        o_dp_clk     = 1'b0;
        o_dp_data    = 32'h0;
        o_dp_func    = 4'h0;
        o_dp_update  = 1'b0;
        o_dp_prof    = 3'h0;
        o_ramp_dir   = 1'b0;
        o_ramp_pause = 1'b0;
    end

    // One frame: pins settle, the dp clock pulses, then the bus is released.
    // Four core cycles on each side keep the sampling window clean.
    task automatic frame(input logic [31:0] d, input logic [FUNC_W-1:0] f, input logic u,
                         input logic [PROF_W-1:0] p, input logic dir, input logic hold);
        @(posedge i_clk);
        o_dp_data    <= d;
        o_dp_func    <= f;
        o_dp_update  <= u;
        o_dp_prof    <= p;
        o_ramp_dir   <= dir;
        o_ramp_pause <= hold;
        repeat (4) @(posedge i_clk);
        o_dp_clk <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_dp_clk <= 1'b0;
        repeat (4) @(posedge i_clk);
        // Released lines show the inverse so a stale value cannot pass.
        o_dp_data   <= ~d;
        o_dp_func   <= ~f;
        o_dp_update <= ~u;
    endtask
endmodule // dp_host_model

// File: synth_lat_pkg.sv
package synth_lat_pkg;

    // =====================================================================
    // Widths.
    localparam int FREQ_W  = 32;
    localparam int PHASE_W = 16;
    localparam int AMP_W   = 12;
    localparam int LAT_W   = 9;
    localparam int PTR_W   = 8;
    localparam int PROF_W  = 3;
    localparam int FUNC_W  = 4;
    localparam int ADDR_W  = 8;

    // =====================================================================
    // Pipeline delays in core sample clock cycles.
    localparam logic [LAT_W-1:0] LAT_FREQ_BASE  = 9'h0de;
    localparam logic [LAT_W-1:0] LAT_PHASE_BASE = 9'h0ce;
    localparam logic [LAT_W-1:0] LAT_AMP_BASE   = 9'h04e;
    localparam logic [LAT_W-1:0] LAT_AMP_ALIGN  = 9'h0ee;
    localparam logic [LAT_W-1:0] LAT_SWEEP_ADD  = 9'h010;
    localparam logic [LAT_W-1:0] LAT_KEY_ADD    = 9'h010;
    localparam logic [LAT_W-1:0] LAT_ONE        = 9'h001;

    // =====================================================================
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FREQ   = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PHASE  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_AMP    = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STEP   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_LAT    = 8'h18;

    // =====================================================================
    // Modes, data port function codes and carriers.
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_DPORT  = 2'b01,
        MODE_SWEEP  = 2'b10
    } mode_t;

    localparam logic [FUNC_W-1:0] FN_FREQ  = 4'h1;
    localparam logic [FUNC_W-1:0] FN_PHASE = 4'h2;
    localparam logic [FUNC_W-1:0] FN_AMP   = 4'h3;

    typedef struct packed {
        logic  amplitude_keying_enable;
        logic  align;
        mode_t mode;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{1'b0, 1'b0, MODE_SINGLE};

    typedef struct packed {
        logic [FUNC_W-1:0] func;
        logic [PROF_W-1:0] prof;
        logic              ramp_dir;
        logic              ramp_pause;
        logic              upd;
    } pins_t;

    typedef struct packed {
        logic [FREQ_W-1:0]  freq;
        logic [PHASE_W-1:0] phase;
        logic [AMP_W-1:0]   amp;
    } word_t;

    typedef struct packed {
        logic [2:0]        dpc_sh;
        logic [31:0]       d_s1;
        logic [31:0]       d_s2;
        pins_t             p_s1;
        pins_t             p_s2;
        logic [31:0]       d_cap;
        pins_t             p_cap;
        ctrl_t             ctrl;
        word_t             pend;
        word_t             act;
        logic [FREQ_W-1:0] step;
        logic [PTR_W-1:0]  wp;
        logic              filled;
        word_t             out;
        logic [31:0]       prdata;
    } state_t;

endpackage

// File: synth_pipeline_latency.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
// What this block does
// - Single/profile, unaligned: freq 222, phase 206, amp 78; keying adds 16 to freq and phase.
// - Single/profile, aligned: freq and phase 222 plain, 238 keyed; amp 238.
// - Data port, unaligned: freq 222, phase 206, amp 78; keying adds 16 to freq and phase.
// - Data port, aligned: freq and phase 222 plain, 238 keyed; amp 238.
// - Sweep, unaligned: freq 238, phase 222, amp 94; keying adds 16 to freq and phase.
// - Sweep, aligned: freq and phase 238 plain, 254 keyed; amp 254.
// - Data bus captured on data port clock.
// - Function select sampled on data port clock.
// - Update strobe sampled on data port clock.
// - Profile select sampled on data port clock.
// - Ramp direction and pause sampled likewise.
module synth_pipeline_latency
    import synth_lat_pkg::*;
(
    // Core sample clock and reset.
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    // APB slave.
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ADDR_W-1:0]    i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    // Data port pins, synchronous to the data port clock.
    input  wire logic                 i_dp_clk,
    input  wire logic [31:0]          i_dp_data,
    input  wire logic [FUNC_W-1:0]    i_dp_func,
    input  wire logic                 i_dp_update,
    input  wire logic [PROF_W-1:0]    i_dp_prof,
    input  wire logic                 i_ramp_direction_input,
    input  wire logic                 i_ramp_pause_input,
    // Delayed synthesis words.
    output logic      [FREQ_W-1:0]    o_freq,
    output logic      [PHASE_W-1:0]   o_phase,
    output logic      [AMP_W-1:0]     o_amp
);

    // =====================================================================
    // State and delay line.
    localparam int DEPTH = 1 << PTR_W;

    state_t           st_ff;
    state_t           nxt_st;
    word_t            mem [DEPTH];
    logic [LAT_W-1:0] lat_f;
    logic [LAT_W-1:0] lat_p;
    logic [LAT_W-1:0] lat_a;
    logic [LAT_W-1:0] sw_add;
    logic [LAT_W-1:0] ky_add;
    logic [PTR_W-1:0] rd_f;
    logic [PTR_W-1:0] rd_p;
    logic [PTR_W-1:0] rd_a;
    logic             dp_rise;
    logic             hit;
    logic             wr_en;
    logic [31:0]      rd_mux;

    // =====================================================================
    // Delay selection from the active mode and settings.
    always_comb begin
        sw_add = (st_ff.ctrl.mode == MODE_SWEEP) ? LAT_SWEEP_ADD : '0;
        ky_add = st_ff.ctrl.amplitude_keying_enable ? LAT_KEY_ADD : '0;
        lat_f  = LAT_FREQ_BASE + sw_add + ky_add;
        lat_p  = LAT_PHASE_BASE + sw_add + ky_add;
        lat_a  = LAT_AMP_BASE + sw_add;
        if (st_ff.ctrl.align) begin
            // Alignment pads phase up to the frequency path and amplitude to the keyed frequency path.
            lat_p = lat_f;
            lat_a = LAT_AMP_ALIGN + sw_add;
        end
    end

    // The write lands one edge after the change, so read back one less.
    assign rd_f = st_ff.wp - lat_f[PTR_W-1:0] + LAT_ONE[PTR_W-1:0];
    assign rd_p = st_ff.wp - lat_p[PTR_W-1:0] + LAT_ONE[PTR_W-1:0];
    assign rd_a = st_ff.wp - lat_a[PTR_W-1:0] + LAT_ONE[PTR_W-1:0];

    // Rising edge of the synchronised data port clock; stage 0 is not read.
    assign dp_rise = st_ff.dpc_sh[1] & ~st_ff.dpc_sh[2];

    // =====================================================================
    // APB decode. Zero wait states; unmapped addresses answer with an error.
    always_comb begin
        hit    = 1'b1;
        rd_mux = '0;
        unique case (i_paddr)
            ADDR_CTRL:   rd_mux = 32'(st_ff.ctrl);
            ADDR_FREQ:   rd_mux = st_ff.pend.freq;
            ADDR_PHASE:  rd_mux = 32'(st_ff.pend.phase);
            ADDR_AMP:    rd_mux = 32'(st_ff.pend.amp);
            ADDR_STEP:   rd_mux = st_ff.step;
            ADDR_STATUS: rd_mux = 32'(st_ff.p_cap);
            ADDR_LAT:    rd_mux = {8'h00, lat_a[7:0], lat_p[7:0], lat_f[7:0]};
            default:     hit = 1'b0;
        endcase
    end

    assign wr_en     = i_psel & i_penable & i_pwrite & hit;
    assign o_pready  = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~hit;

    // =====================================================================
    // Next state.
    always_comb begin
        nxt_st = st_ff;
        // Two flops on every data port pin before any logic reads it.
        nxt_st.dpc_sh = {st_ff.dpc_sh[1:0], i_dp_clk};
        nxt_st.d_s1   = i_dp_data;
        nxt_st.d_s2   = st_ff.d_s1;
        nxt_st.p_s1   = '{i_dp_func, i_dp_prof, i_ramp_direction_input,
                          i_ramp_pause_input, i_dp_update};
        nxt_st.p_s2   = st_ff.p_s1;
        // Data and control pins share the clock's sync delay, so the word
        // seen at the rising edge is the one the host set up for it.
        if (dp_rise) begin
            nxt_st.d_cap = st_ff.d_s2;
            nxt_st.p_cap = st_ff.p_s2;
            // One profile change per period is assumed; faster is lost.
            nxt_st.p_cap.prof = st_ff.p_s2.prof;
            nxt_st.p_cap.ramp_dir   = st_ff.p_s2.ramp_dir;
            nxt_st.p_cap.ramp_pause = st_ff.p_s2.ramp_pause;
        end
        // Software writes land in the pending set, except control and step, which take effect at once.
        if (wr_en) begin
            unique case (i_paddr)
                ADDR_CTRL:  nxt_st.ctrl = ctrl_t'(i_pwdata[3:0]);
                ADDR_FREQ:  nxt_st.pend.freq = i_pwdata;
                ADDR_PHASE: nxt_st.pend.phase = i_pwdata[PHASE_W-1:0];
                ADDR_AMP:   nxt_st.pend.amp = i_pwdata[AMP_W-1:0];
                ADDR_STEP:  nxt_st.step = i_pwdata;
                default:    nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // Sweep runs every core cycle unless paused; loads below win.
        if (st_ff.ctrl.mode == MODE_SWEEP && !st_ff.p_cap.ramp_pause) begin
            nxt_st.act.freq = st_ff.p_cap.ramp_dir ? st_ff.act.freq + st_ff.step
                                                   : st_ff.act.freq - st_ff.step;
        end
        // Update strobe moves the pending set into the active set.
        if (dp_rise && st_ff.p_s2.upd) begin
            nxt_st.act = st_ff.pend;
        end
        // Data port modulation writes one field per edge from the bus.
        if (dp_rise && st_ff.ctrl.mode == MODE_DPORT) begin
            if (st_ff.p_s2.func == FN_FREQ) begin
                nxt_st.act.freq = st_ff.d_s2;
            end
            if (st_ff.p_s2.func == FN_PHASE) begin
                nxt_st.act.phase = st_ff.d_s2[PHASE_W-1:0];
            end
            if (st_ff.p_s2.func == FN_AMP) begin
                nxt_st.act.amp = st_ff.d_s2[AMP_W-1:0];
            end
        end
        // Ring pointer; outputs stay zero until every slot has been written.
        nxt_st.wp = st_ff.wp + 8'h01;
        if (&st_ff.wp) begin
            nxt_st.filled = 1'b1;
        end
        if (st_ff.filled) begin
            nxt_st.out.freq  = mem[rd_f].freq;
            nxt_st.out.phase = mem[rd_p].phase;
            nxt_st.out.amp   = mem[rd_a].amp;
        end
        // Read data is latched in the setup phase.
        if (i_psel && !i_penable) begin
            nxt_st.prdata = rd_mux;
        end
    end

    // =====================================================================
    // State register.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_ff      <= '0;
            st_ff.ctrl <= CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // The ring is not reset; the filled flag hides its stale contents.
    always_ff @(posedge i_clk) begin
        mem[st_ff.wp] <= st_ff.act;
    end

    assign o_prdata = st_ff.prdata;
    assign o_freq   = st_ff.out.freq;
    assign o_phase  = st_ff.out.phase;
    assign o_amp    = st_ff.out.amp;

    // =====================================================================
    // Checks.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Tracks one frequency change through the pipeline at a time.
    logic [LAT_W-1:0]  chk_cnt;
    logic              chk_run;
    logic [FREQ_W-1:0] chk_val;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            chk_run <= 1'b0;
            chk_cnt <= '0;
            chk_val <= '0;
        end else if (!chk_run) begin
            chk_run <= st_ff.filled && (nxt_st.act.freq != st_ff.act.freq)
                       && (nxt_st.ctrl == st_ff.ctrl);
            chk_cnt <= LAT_ONE;
            chk_val <= nxt_st.act.freq;
        end else begin
            chk_run <= (chk_cnt != lat_f) && (nxt_st.ctrl == st_ff.ctrl);
            chk_cnt <= chk_cnt + LAT_ONE;
        end
    end

    a_freq_pipe_exact: assert property (
        chk_run && chk_cnt == lat_f && $stable(st_ff.ctrl) |=> o_freq == chk_val)
        else $error("frequency word left the pipeline at the wrong cycle");
    a_lat_single_off: assert property (
        st_ff.ctrl.mode == MODE_SINGLE && !st_ff.ctrl.align
        |-> lat_p == (st_ff.ctrl.amplitude_keying_enable ? 9'h0de : 9'h0ce)
            && lat_a == 9'h04e)
        else $error("single tone unaligned delay wrong");
    a_lat_single_on: assert property (
        st_ff.ctrl.mode == MODE_SINGLE && st_ff.ctrl.align
        |-> lat_f == lat_p && lat_a == 9'h0ee
            && lat_f == (st_ff.ctrl.amplitude_keying_enable ? 9'h0ee : 9'h0de))
        else $error("single tone aligned delay wrong");
    a_lat_dport_off: assert property (
        st_ff.ctrl.mode == MODE_DPORT && !st_ff.ctrl.align
        |-> lat_f == (st_ff.ctrl.amplitude_keying_enable ? 9'h0ee : 9'h0de)
            && lat_p == lat_f - 9'h010 && lat_a == 9'h04e)
        else $error("data port unaligned delay wrong");
    a_lat_dport_on: assert property (
        st_ff.ctrl.mode == MODE_DPORT && st_ff.ctrl.align
        |-> lat_p == lat_f && lat_a == 9'h0ee)
        else $error("data port aligned delay wrong");
    a_lat_sweep_off: assert property (
        st_ff.ctrl.mode == MODE_SWEEP && !st_ff.ctrl.align
        |-> lat_f == (st_ff.ctrl.amplitude_keying_enable ? 9'h0fe : 9'h0ee)
            && lat_p == lat_f - 9'h010 && lat_a == 9'h05e)
        else $error("sweep unaligned delay wrong");
    a_lat_sweep_on: assert property (
        st_ff.ctrl.mode == MODE_SWEEP && st_ff.ctrl.align
        |-> lat_p == lat_f && lat_a == 9'h0fe)
        else $error("sweep aligned delay wrong");
    a_data_capture: assert property (
        dp_rise |=> st_ff.d_cap == $past(i_dp_data, 3))
        else $error("data bus not captured at the port clock edge");
    a_func_capture: assert property (
        dp_rise |=> st_ff.p_cap.func == $past(i_dp_func, 3))
        else $error("function select not sampled at the port clock edge");
    a_update_load: assert property (
        dp_rise && st_ff.p_s2.upd && st_ff.ctrl.mode != MODE_DPORT
        |=> st_ff.act == $past(st_ff.pend))
        else $error("update strobe did not load the active words");
    a_prof_capture: assert property (
        dp_rise |=> st_ff.p_cap.prof == $past(i_dp_prof, 3))
        else $error("profile select not sampled at the port clock edge");
    a_ramp_step: assert property (
        st_ff.ctrl.mode == MODE_SWEEP && !st_ff.p_cap.ramp_pause
        && !(dp_rise && st_ff.p_s2.upd) && st_ff.p_cap.ramp_dir
        |=> st_ff.act.freq == $past(st_ff.act.freq) + $past(st_ff.step))
        else $error("sweep did not step upward");

    c_freq_through: cover property (chk_run && chk_cnt == lat_f);
    c_dport_write: cover property (
        dp_rise && st_ff.ctrl.mode == MODE_DPORT && st_ff.p_s2.func == FN_FREQ);
    c_sweep_pause: cover property (
        st_ff.ctrl.mode == MODE_SWEEP && st_ff.p_cap.ramp_pause);

endmodule // synth_pipeline_latency

// File: testbench.sv
`timescale 1ns/100ps
// =====================================================================
// Latency bench: every mode, alignment and keying setting in turn.
module testbench
    import synth_lat_pkg::*;
;
    logic              i_clk;
    logic              i_nrst;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              dp_clk;
    logic [31:0]       dp_data;
    logic [FUNC_W-1:0] dp_func;
    logic              dp_upd;
    logic [PROF_W-1:0] dp_prof;
    logic              rdir;
    logic              rpause;
    logic [31:0]       o_freq;
    logic [15:0]       o_phase;
    logic [11:0]       o_amp;
    int                mismatches;
    int                samples_checked;
    int                cyc;

    synth_pipeline_latency synth_pipeline_latency_inst (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_dp_clk(dp_clk), .i_dp_data(dp_data),
        .i_dp_func(dp_func), .i_dp_update(dp_upd), .i_dp_prof(dp_prof),
        .i_ramp_direction_input(rdir), .i_ramp_pause_input(rpause),
        .o_freq(o_freq), .o_phase(o_phase), .o_amp(o_amp));

    dp_host_model dp_host_model_inst (
        .i_clk(i_clk), .o_dp_clk(dp_clk), .o_dp_data(dp_data), .o_dp_func(dp_func),
        .o_dp_update(dp_upd), .o_dp_prof(dp_prof), .o_ramp_dir(rdir),
        .o_ramp_pause(rpause));

    // =====================================================================
    // Clock, and a timeout well above the twelve rounds of about 330 cycles.
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 9000) begin
            mismatches++;
            results();
        end
    end

    // =====================================================================
    // Shared tasks.
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(what, rd, e);
    endtask

    // Delay figures per field: 0 frequency, 1 phase, 2 amplitude.
    function automatic int lat(int m, int al, int key, int fld);
        int v;
        if (fld == 2) v = al ? 238 : 78;
        else v = (fld == 1 && al == 0) ? 206 + 16 * key : 222 + 16 * key;
        return (m == 2) ? v + 16 : v;
    endfunction

    // =====================================================================
    // Main sequence.
    initial begin
        logic [31:0] rd, pf, ef, d, ctl;
        logic [15:0] ep;
        logic [11:0] ea;
        logic [3:0]  f;
        logic        err;
        int          m, al, key, lf, lp, la, tf, tp, ta;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        i_nrst = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (300) @(posedge i_clk);
        wr(ADDR_STEP, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, rd, err);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        for (int k = 0; k < 12; k++) begin
            m = k / 4;
            al = (k / 2) % 2;
            key = k % 2;
            ctl = {28'h0, key[0], al[0], m[1:0]};
            pf = 32'h1000_0000 + k;
            ep = 16'h0100 + k[15:0];
            ea = 12'h100 + k[11:0];
            d = 32'h2000_0abc ^ k;
            f = 4'(1 + k % 3);
            wr(ADDR_CTRL, ctl);
            rdchk("ctrl", ADDR_CTRL, ctl);
            wr(ADDR_FREQ, pf);
            wr(ADDR_PHASE, {16'h0, ep});
            wr(ADDR_AMP, {20'h0, ea});
            ef = pf;
            // Data port mode lets the function code override one field.
            if (m == 1 && f == FN_FREQ) ef = d;
            if (m == 1 && f == FN_PHASE) ep = d[15:0];
            if (m == 1 && f == FN_AMP) ea = d[11:0];
            lf = lat(m, al, key, 0);
            lp = lat(m, al, key, 1);
            la = lat(m, al, key, 2);
            rdchk("lat reg", ADDR_LAT, {8'h0, la[7:0], lp[7:0], lf[7:0]});
            fork
                dp_host_model_inst.frame(d, f, 1'b1, k[2:0], k[0], k[1]);
                begin
                    @(posedge dp_clk);
                    {tf, tp, ta} = '0;
                    for (int n = 1; n <= 300; n++) begin
                        @(posedge i_clk);
                        #1;
                        if (tf == 0 && o_freq === ef) tf = n;
                        if (tp == 0 && o_phase === ep) tp = n;
                        if (ta == 0 && o_amp === ea) ta = n;
                    end
                end
            join
            // The three extra cycles are the dp clock capture path: two sync
            // flops, then the capture edge that loads the active words.
            check("freq delay", tf, 3 + lf);
            check("phase delay", tp, 3 + lp);
            check("amp delay", ta, 3 + la);
            rdchk("status", ADDR_STATUS, {22'h0, f, k[2:0], k[0], k[1], 1'b1});
            $display("test round %0d done", k);
        end
        // Sweep with a real step: a zero step would hide a broken ramp adder.
        wr(ADDR_STEP, 32'h1);
        dp_host_model_inst.frame(32'h0, 4'h0, 1'b0, 3'h0, 1'b1, 1'b0);
        repeat (300) @(posedge i_clk);
        #1;
        ef = o_freq;
        @(posedge i_clk);
        #1;
        check("sweep step", o_freq - ef, 32'h1);
        $display("test sweep step done");
        results();
    end
endmodule // testbench
